// ---- design/ctrl_port_defines.svh ----
// Constants of the two-wire control port: target address, register space, reset times.
// Assumes inclusion by the package and the design modules by bare name.
`ifndef CTRL_PORT_DEFINES_SVH
`define CTRL_PORT_DEFINES_SVH
`define TARGET_ADDR        7'h18
`define REG_ADDR_W         8
`define REG_DATA_W         8
`define REG_COUNT          256
`define REG_RESET_VAL      8'h00
`define SW_RESET_REG       8'h01
`define SW_RESET_BIT       0
`define CLK_PERIOD_NS      50
`define INIT_TIME_NS       1000000
`define INIT_CYCLES        ((`INIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ---- design/ctrl_port_pkg.sv ----
// Types shared by the control port and its register memory.
// Assumes the defines header is on the include path.
`include "ctrl_port_defines.svh"
package ctrl_port_pkg;
  typedef enum logic [2:0] {
    st_idle  = 3'b000,
    st_addr  = 3'b001,
    st_ack   = 3'b010,
    st_wbyte = 3'b011,
    st_rbyte = 3'b100,
    st_rack  = 3'b101
  } bus_state_t;

  // One write or read request toward the register memory
  typedef struct packed {
    logic                     wr;
    logic [`REG_ADDR_W-1:0]   addr;
    logic [`REG_DATA_W-1:0]   data;
  } reg_req_t;
endpackage : ctrl_port_pkg

// ---- design/reg_mem.sv ----
// Register memory of the control port: 256 eight-bit registers, registered read data.
// Assumes a single clock; clearing walks the whole space one word a cycle.
`include "ctrl_port_defines.svh"
module reg_mem (
  input  wire logic                    ref_clk,
  input  wire logic                    reset,
  input  wire logic                    clr_start,
  input  wire ctrl_port_pkg::reg_req_t req,
  input  wire logic                    req_en,
  output logic [`REG_DATA_W-1:0]       rd_data,
  output logic                         clr_busy
);
  logic [`REG_DATA_W-1:0] mem [`REG_COUNT];
  logic [`REG_ADDR_W-1:0] clr_addr_ff;
  logic                   clr_busy_ff;

  assign clr_busy = clr_busy_ff;

  // Walk through all registers loading the default value
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      clr_busy_ff <= 1'b1;
      clr_addr_ff <= '0;
    end else if (clr_start) begin
      clr_busy_ff <= 1'b1;
      clr_addr_ff <= '0;
    end else if (clr_busy_ff) begin
      clr_addr_ff <= clr_addr_ff + 8'h01;
      if (clr_addr_ff == 8'hff) begin
        clr_busy_ff <= 1'b0;
      end
    end
  end

  // Storage: clearing has priority over bus writes
  always_ff @(posedge ref_clk) begin
    if (clr_busy_ff) begin
      mem[clr_addr_ff] <= `REG_RESET_VAL;
    end else if (req_en && req.wr) begin
      mem[req.addr] <= req.data;
    end
  end

  // Registered read port
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rd_data <= '0;
    end else if (req_en && !req.wr) begin
      rd_data <= mem[req.addr];
    end
  end
endmodule : reg_mem

// ---- design/ctrl_port.sv ----
// Two-wire target control port giving the host access to 256 eight-bit registers.
// Assumes SCL and SDA arrive from pins; SDA is open drain, driven low only.
`include "ctrl_port_defines.svh"
module ctrl_port (
  input  wire logic                   ref_clk,
  input  wire logic                   reset,
  input  wire logic                   scl_in,
  input  wire logic                   sda_in,
  output logic                        sda_out,
  output logic                        sda_oe,
  output logic                        scl_oe,
  output logic                        init_busy,
  output logic [`REG_ADDR_W-1:0]      reg_ptr
);
  logic [1:0] scl_sync_ff;
  logic [1:0] sda_sync_ff;
  logic       scl_d_ff;
  logic       sda_d_ff;
  ctrl_port_pkg::bus_state_t state_ff;
  logic [7:0] shift_ff;
  logic [3:0] bit_cnt_ff;
  logic       rw_ff;
  logic       ptr_set_ff;
  logic [`REG_ADDR_W-1:0] ptr_ff;
  logic       sda_low_ff;
  logic       sw_reset_ff;
  logic [15:0] init_cnt_ff;
  logic       mem_busy;
  logic [`REG_DATA_W-1:0] rd_data;
  ctrl_port_pkg::reg_req_t req;
  logic       req_en;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;
  logic       byte_done;
  logic       addr_match;

  // Two-flop synchronisers for the bus pins
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      scl_sync_ff <= 2'b11;
      sda_sync_ff <= 2'b11;
      scl_d_ff    <= 1'b1;
      sda_d_ff    <= 1'b1;
    end else begin
      scl_sync_ff <= {scl_sync_ff[0], scl_in};
      sda_sync_ff <= {sda_sync_ff[0], sda_in};
      scl_d_ff    <= scl_sync_ff[1];
      sda_d_ff    <= sda_sync_ff[1];
    end
  end

  // Edge and condition detection on synchronised levels, sampled well within 100/400 kHz
  assign scl_rise   = scl_sync_ff[1] && !scl_d_ff;
  assign scl_fall   = !scl_sync_ff[1] && scl_d_ff;
  assign start_seen = scl_sync_ff[1] && scl_d_ff && !sda_sync_ff[1] && sda_d_ff;
  assign stop_seen  = scl_sync_ff[1] && scl_d_ff && sda_sync_ff[1] && !sda_d_ff;
  assign byte_done  = (bit_cnt_ff == 4'd8);
  assign addr_match = (shift_ff[7:1] == `TARGET_ADDR);

  // Clock line is never driven; only SDA is pulled low for ack and read data
  assign scl_oe  = 1'b0;
  assign sda_out = 1'b0;
  assign sda_oe  = sda_low_ff;
  assign reg_ptr = ptr_ff;
  assign init_busy = mem_busy || (init_cnt_ff != 16'h0000);

  // Startup lockout counter after any reset
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      init_cnt_ff <= 16'(`INIT_CYCLES);
    end else if (sw_reset_ff) begin
      init_cnt_ff <= 16'(`INIT_CYCLES);
    end else if (init_cnt_ff != 16'h0000) begin
      init_cnt_ff <= init_cnt_ff - 16'h0001;
    end
  end

  // Bus state machine: address, pointer, data phases
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_ff   <= ctrl_port_pkg::st_idle;
      shift_ff   <= 8'h00;
      bit_cnt_ff <= 4'd0;
      rw_ff      <= 1'b0;
      ptr_set_ff <= 1'b0;
      sda_low_ff <= 1'b0;
    end else if (sw_reset_ff) begin
      state_ff   <= ctrl_port_pkg::st_idle;
      sda_low_ff <= 1'b0;
      bit_cnt_ff <= 4'd0;
    end else if (stop_seen) begin
      state_ff   <= ctrl_port_pkg::st_idle;
      sda_low_ff <= 1'b0;
    end else if (start_seen) begin
      state_ff   <= ctrl_port_pkg::st_addr;
      bit_cnt_ff <= 4'd0;
      sda_low_ff <= 1'b0;
      ptr_set_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        ctrl_port_pkg::st_idle: begin
          sda_low_ff <= 1'b0;
        end
        ctrl_port_pkg::st_addr, ctrl_port_pkg::st_wbyte: begin
          if (scl_rise && !byte_done) begin
            shift_ff   <= {shift_ff[6:0], sda_sync_ff[1]};
            bit_cnt_ff <= bit_cnt_ff + 4'd1;
          end else if (scl_fall && byte_done) begin
            bit_cnt_ff <= 4'd0;
            if (state_ff == ctrl_port_pkg::st_addr) begin
              if (addr_match) begin
                rw_ff      <= shift_ff[0];
                sda_low_ff <= 1'b1;
                state_ff   <= ctrl_port_pkg::st_ack;
              end else begin
                state_ff   <= ctrl_port_pkg::st_idle;
              end
            end else begin
              ptr_set_ff <= 1'b1;
              sda_low_ff <= 1'b1;
              state_ff   <= ctrl_port_pkg::st_ack;
            end
          end
        end
        ctrl_port_pkg::st_ack: begin
          if (scl_fall) begin
            if (rw_ff) begin
              shift_ff   <= rd_data;
              sda_low_ff <= !rd_data[7];
              bit_cnt_ff <= 4'd1;
              state_ff   <= ctrl_port_pkg::st_rbyte;
            end else begin
              sda_low_ff <= 1'b0;
              state_ff   <= ctrl_port_pkg::st_wbyte;
            end
          end
        end
        ctrl_port_pkg::st_rbyte: begin
          if (scl_fall) begin
            if (byte_done) begin
              sda_low_ff <= 1'b0;
              bit_cnt_ff <= 4'd0;
              state_ff   <= ctrl_port_pkg::st_rack;
            end else begin
              sda_low_ff <= !shift_ff[7 - bit_cnt_ff[2:0]];
              bit_cnt_ff <= bit_cnt_ff + 4'd1;
            end
          end
        end
        ctrl_port_pkg::st_rack: begin
          if (scl_rise) begin
            state_ff <= sda_sync_ff[1] ? ctrl_port_pkg::st_idle : ctrl_port_pkg::st_ack;
          end
        end
        default: begin
          state_ff <= ctrl_port_pkg::st_idle;
        end
      endcase
    end
  end

  // Memory requests: write on the ack after a data byte, read fetch in every cycle of a read ack
  always_comb begin
    req.wr   = 1'b0;
    req.addr = ptr_ff;
    req.data = shift_ff;
    req_en   = 1'b0;
    if (state_ff == ctrl_port_pkg::st_wbyte && scl_fall && byte_done && ptr_set_ff) begin
      req.wr = 1'b1;
      req_en = 1'b1;
    end else if (state_ff == ctrl_port_pkg::st_ack && rw_ff) begin
      req_en = 1'b1;
    end
  end

  // Register pointer: set by the first write byte, incremented per data byte
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ptr_ff <= '0;
    end else if (sw_reset_ff) begin
      ptr_ff <= '0;
    end else if (state_ff == ctrl_port_pkg::st_wbyte && scl_fall && byte_done) begin
      ptr_ff <= ptr_set_ff ? ptr_ff + 8'h01 : shift_ff;
    end else if (state_ff == ctrl_port_pkg::st_ack && rw_ff && scl_fall) begin
      ptr_ff <= ptr_ff + 8'h01;
    end
  end

  // Software reset pulse from a write of one to the reset bit
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sw_reset_ff <= 1'b0;
    end else begin
      sw_reset_ff <= req_en && req.wr && req.addr == `SW_RESET_REG
                     && req.data[`SW_RESET_BIT];
    end
  end

  reg_mem u_reg_mem (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .clr_start (sw_reset_ff),
    .req       (req),
    .req_en    (req_en && !mem_busy),
    .rd_data   (rd_data),
    .clr_busy  (mem_busy)
  );

  // Clock line is never driven
  no_scl_drive_a: assert property (@(posedge ref_clk) disable iff (reset)
    !scl_oe) else $error("clock line driven");

  // Unmatched address never acknowledged
  addr_reject_a: assert property (@(posedge ref_clk) disable iff (reset)
    (state_ff == ctrl_port_pkg::st_addr && scl_fall && byte_done && !addr_match)
    |=> state_ff == ctrl_port_pkg::st_idle && !sda_oe) else $error("foreign address acked");

  // Pointer steps by one as each read byte starts, at the clock fall ending the ack
  ptr_step_a: assert property (@(posedge ref_clk) disable iff (reset)
    (state_ff == ctrl_port_pkg::st_ack && rw_ff && scl_fall && !sw_reset_ff)
    |=> ptr_ff == $past(ptr_ff) + 8'h01) else $error("pointer did not step");

  // Software reset starts a clear and lockout
  sw_reset_a: assert property (@(posedge ref_clk) disable iff (reset)
    sw_reset_ff |=> mem_busy && init_busy && ptr_ff == 8'h00) else $error("soft reset lost");

  // First write byte loads pointer without writing
  ptr_load_a: assert property (@(posedge ref_clk) disable iff (reset)
    (state_ff == ctrl_port_pkg::st_wbyte && scl_fall && byte_done && !ptr_set_ff
     && !sw_reset_ff && !stop_seen && !start_seen)
    |-> !req.wr ##1 ptr_ff == $past(shift_ff)) else $error("pointer load wrong");

  // Clear walk ends within the register count
  clear_done_a: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(mem_busy) |-> ##[1:257] !mem_busy) else $error("clear never ends");

  // Acknowledge, once driven, holds SDA low until the clock falls; checked in the ack state only
  ack_drive_a: assert property (@(posedge ref_clk) disable iff (reset)
    (state_ff == ctrl_port_pkg::st_ack && !scl_fall && $past(sda_oe)) |-> sda_oe)
    else $error("ack released");

  // Each write moves the byte just shifted in and advances the pointer by one register
  write_data_a: assert property (@(posedge ref_clk) disable iff (reset)
    (req_en && req.wr && !sw_reset_ff) |-> req.data == shift_ff
    ##1 ptr_ff == $past(req.addr) + 8'h01) else $error("write step mismatch");
endmodule : ctrl_port

// ---- testbench/i2c_host_model.sv ----
// Two-wire bus host model: makes START, STOP, the clock and bytes at 400 kHz.
// Assumes an open-drain data wire resolved outside from both enables, with a pull-up.
module i2c_host_model #(
  parameter int HALF = 25
) (
  input  wire logic ref_clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ps;

  // Bus idles released: clock and data high
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wait_clk

  // Start or repeated start; the host alone makes every start and stop
  task automatic start;
    sda_low <= 1'b0;
    wait_clk(HALF);
    scl <= 1'b1;
    wait_clk(HALF);
    sda_low <= 1'b1;
    wait_clk(HALF);
    scl <= 1'b0;
    wait_clk(HALF);
  endtask : start

  // Stop: data rises while the clock is high
  task automatic stop;
    wait_clk(4);
    sda_low <= 1'b1;
    wait_clk(HALF);
    scl <= 1'b1;
    wait_clk(HALF);
    sda_low <= 1'b0;
    wait_clk(HALF);
  endtask : stop

  // One clock pulse of 2 x HALF cycles, 400 kHz; data moves only while SCL is low
  task automatic bit_io(input logic b, output logic r);
    wait_clk(4);
    sda_low <= ~b;
    wait_clk(HALF - 4);
    scl <= 1'b1;
    wait_clk(HALF);
    r = sda_line;
    scl <= 1'b0;
  endtask : bit_io

  // Eight bits MSB first, then the acknowledge slot with data released
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask : put_byte

  // Reads eight bits, then acknowledges, or not when last is set
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, b[i]);
    end
    bit_io(last, r);
  endtask : get_byte
endmodule : i2c_host_model

// ---- testbench/codec_i2c_control_port_bench.sv ----
// Self-checking bench of the two-wire control port, driven by the host model.
// Assumes the design's defines header on the include path and a 20 MHz clock.
`include "ctrl_port_defines.svh"
`define CHECK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("Error at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module codec_i2c_control_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   ref_clk, reset, scl, sda_low;
  logic                   sda_out, sda_oe, scl_oe, init_busy;
  logic [`REG_ADDR_W-1:0] reg_ptr;
  int                     num_errors, samples_checked;
  wire                    sda_line = ~sda_low & ~(sda_oe & ~sda_out);

  ctrl_port DUT (.ref_clk(ref_clk), .reset(reset), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .scl_oe(scl_oe), .init_busy(init_busy),
    .reg_ptr(reg_ptr));
  i2c_host_model HOST (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

  // 50 ns clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic end_sim;
    $display("Checks %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  // Lockout holds its full length, then ends; traffic waits for it
  task automatic wait_init;
    repeat (`INIT_CYCLES - 300) @(posedge ref_clk);
    `CHECK(init_busy, 1'b1)
    for (int i = 0; i < 600 && init_busy !== 1'b0; i++) @(posedge ref_clk);
    `CHECK(init_busy, 1'b0)
  endtask : wait_init

  // Pointer, then data bytes, each acknowledged
  task automatic wr_seq(input logic [7:0] ptr, input logic [7:0] d [$]);
    logic ack;
    HOST.start();
    HOST.put_byte({`TARGET_ADDR, 1'b0}, ack);
    `CHECK(ack, 1'b1)
    HOST.put_byte(ptr, ack);
    `CHECK(ack, 1'b1)
    foreach (d[i]) begin
      HOST.put_byte(d[i], ack);
      `CHECK(ack, 1'b1)
    end
    HOST.stop();
  endtask : wr_seq

  // Pointer set, repeated start, then reads compared byte by byte
  task automatic rd_seq(input logic [7:0] ptr, input logic [7:0] e [$]);
    logic       ack;
    logic [7:0] b;
    HOST.start();
    HOST.put_byte({`TARGET_ADDR, 1'b0}, ack);
    HOST.put_byte(ptr, ack);
    HOST.start();
    HOST.put_byte({`TARGET_ADDR, 1'b1}, ack);
    `CHECK(ack, 1'b1)
    foreach (e[i]) begin
      HOST.get_byte(i == e.size() - 1, b);
      `CHECK(b, e[i])
    end
    HOST.stop();
  endtask : rd_seq

  task automatic t_reset;
    `CHECK(init_busy, 1'b1)
    `CHECK(reg_ptr, 8'h00)
    `CHECK(scl_oe, 1'b0)
    wait_init();
  endtask : t_reset

  // A neighbouring address gets no acknowledge for itself or later bytes
  task automatic t_wrong_addr;
    logic ack;
    HOST.start();
    HOST.put_byte({7'h19, 1'b0}, ack);
    `CHECK(ack, 1'b0)
    HOST.put_byte(8'h10, ack);
    `CHECK(ack, 1'b0)
    HOST.stop();
  endtask : t_wrong_addr

  task automatic t_write_read;
    wr_seq(8'h10, '{8'ha5, 8'h5a, 8'hc3});
    `CHECK(reg_ptr, 8'h13)
    rd_seq(8'h10, '{8'ha5, 8'h5a, 8'hc3});
    `CHECK(reg_ptr, 8'h13)
  endtask : t_write_read

  // Pointer wraps from the top register to register zero
  task automatic t_wrap;
    wr_seq(8'hff, '{8'h3c, 8'h96});
    `CHECK(reg_ptr, 8'h01)
    rd_seq(8'hff, '{8'h3c, 8'h96});
  endtask : t_wrap

  // Soft reset bit restarts the lockout and clears written registers
  task automatic t_soft_reset;
    logic ack;
    HOST.start();
    HOST.put_byte({`TARGET_ADDR, 1'b0}, ack);
    HOST.put_byte(`SW_RESET_REG, ack);
    HOST.put_byte(8'h01, ack);
    HOST.stop();
    `CHECK(init_busy, 1'b1)
    `CHECK(reg_ptr, 8'h00)
    wait_init();
    rd_seq(8'h10, '{8'h00, 8'h00});
  endtask : t_soft_reset

  // Reset for 20 cycles, then the scenarios
  initial begin
    num_errors = 0;
    samples_checked = 0;
    reset = 1'b1;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_wrong_addr();
    t_write_read();
    t_wrap();
    t_soft_reset();
    end_sim();
  end

  // Watchdog past the two lockouts and about thirty bytes of traffic
  initial begin
    repeat (90000) @(posedge ref_clk);
    num_errors++;
    end_sim();
  end
endmodule : codec_i2c_control_port_bench
